// >>> hall_commutation_decoder_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module hall_commutation_decoder_tb_top;
  import hcd_pkg::*;
  logic mclk = 0, rst_b = 0, overcurrent = 0, thermal_shutdown = 0;
  logic hall_in_a, hall_in_b, hall_in_c, shoot;
  logic upper_drive_a, upper_drive_b, upper_drive_c;
  logic lower_drive_a, lower_drive_b, lower_drive_c;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, s_axi_rdata;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [2:0] pos = 0, inj_code = 0;
  logic mode60 = 1, inject = 0;
  int fail_count = 0, samples_checked = 0;
  always #10 mclk = ~mclk;
  hcd_top u_dut (.mclk, .rst_b, .hall_in_a, .hall_in_b, .hall_in_c, .overcurrent,
    .thermal_shutdown, .upper_drive_a, .upper_drive_b, .upper_drive_c, .lower_drive_a,
    .lower_drive_b, .lower_drive_c, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  hcd_motor_model u_motor (.pos, .mode60, .inject, .inj_code, .upper_drive_a,
    .upper_drive_b, .upper_drive_c, .lower_drive_a, .lower_drive_b, .lower_drive_c,
    .hall_in_a, .hall_in_b, .hall_in_c, .shoot);
  // Drives packed as {upper c,b,a, lower c,b,a}
  logic [5:0] drv;
  assign drv = {upper_drive_c, upper_drive_b, upper_drive_a,
                lower_drive_c, lower_drive_b, lower_drive_a};
  logic [5:0] drv_seen;
  logic       shoot_seen;
  task automatic finish_test();
    $display("counts: %0d checked, %0d wrong", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic timeout();
    fail_count++;
    $display("wrong value handshake expected done seen timeout");
    finish_test();
  endtask
  // Handshakes judged at the falling edge; inputs only move after rising edges
  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, tw, tb;
    r = RESP_OKAY;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid <= 1;
    s_axi_bready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      tb = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge mclk);
      if (ta) s_axi_awvalid <= 0;
      if (tw) s_axi_wvalid <= 0;
      if (tb) break;
    end
    if (n == 50) timeout();
    s_axi_bready <= 0;
    @(posedge mclk);
  endtask
  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    logic ta, t;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1;
    s_axi_rready <= 1;
    for (n = 0; n < 50; n++) begin
      @(negedge mclk);
      ta = s_axi_arvalid && s_axi_arready;
      t = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge mclk);
      if (ta) s_axi_arvalid <= 0;
      if (t) break;
    end
    if (n == 50) timeout();
    s_axi_rready <= 0;
    @(posedge mclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_write(a, d, r);
    chk("bresp", RESP_OKAY, r);
  endtask
  // Drives are taken at the falling edge, then the bench resumes on a rising edge
  task automatic settle();
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    drv_seen = drv;
    shoot_seen = shoot;
    @(posedge mclk);
  endtask
  task automatic t_regs();
    logic [31:0] d;
    logic [1:0] r;
    axi_read(OFS_CTRL, d, r);
    chk("ctrl reset", {29'h0, CTRL_RESET}, d);
    axi_read(OFS_PERIOD, d, r);
    chk("period reset", PERIOD_RESET, d);
    axi_read(OFS_DUTY, d, r);
    chk("duty reset", DUTY_RESET, d);
    axi_read(4'h2, d, r);
    chk("unmapped rresp", RESP_SLVERR, r);
    chk("unmapped rdata", 0, d);
    axi_write(4'h2, 32'h0000_0005, r);
    chk("unmapped bresp", RESP_SLVERR, r);
    axi_read(OFS_CTRL, d, r);
    chk("ctrl kept", 32'h6, d);
    $display("test registers done");
  endtask
  // Six steps for every mode and direction; lower always on with duty above period
  task automatic t_commutate();
    int m, f, p;
    logic [2:0] tp, bp;
    wr(OFS_PERIOD, 32'h9);
    wr(OFS_DUTY, 32'h20);
    for (m = 1; m >= 0; m--) begin
      for (f = 1; f >= 0; f--) begin
        mode60 <= m[0];
        wr(OFS_CTRL, {29'h0, f[0], m[0], 1'b1});
        for (p = 0; p < 6; p++) begin
          pos <= p[2:0];
          settle();
          tp = 3'h1 << ((p + 1) / 2 % 3);
          bp = 3'h1 << ((p / 2 + 2) % 3);
          if (f == 0) {tp, bp} = {bp, tp};
          chk("drives", {26'h0, ~tp, bp}, drv_seen);
          chk("leg short", 0, shoot_seen);
        end
      end
    end
    $display("test commutation done");
  endtask
  task automatic t_invalid();
    int i;
    logic [2:0] bad [4] = '{3'h5, 3'h2, 3'h0, 3'h7};
    for (i = 0; i < 4; i++) begin
      mode60 <= (i < 2);
      wr(OFS_CTRL, {29'h0, 1'b1, i < 2, 1'b1});
      inject <= 1;
      inj_code <= bad[i];
      settle();
      chk("invalid code drives", 32'h38, drv_seen);
      inject <= 0;
      settle();
    end
    $display("test invalid codes done");
  endtask
  task automatic t_protect();
    logic [31:0] d;
    logic [1:0] r;
    pos <= 0;
    wr(OFS_CTRL, 32'h2);
    settle();
    chk("disabled drives", 32'h38, drv_seen);
    wr(OFS_CTRL, 32'h7);
    overcurrent <= 1;
    settle();
    chk("overcurrent drives", 32'h38, drv_seen);
    overcurrent <= 0;
    thermal_shutdown <= 1;
    settle();
    chk("thermal drives", 32'h38, drv_seen);
    thermal_shutdown <= 0;
    settle();
    chk("restored drives", 32'h34, drv_seen);
    // Code 100 forward: upper a on, lower c on, latch held by full duty
    axi_read(OFS_STATUS, d, r);
    chk("status", 32'h0000_464c, d);
    $display("test protection done");
  endtask
  // Ten periods of ten cycles: on time is duty per period, upper never gated
  task automatic t_pwm();
    int k, lo, up, dt;
    for (dt = 3; dt >= 0; dt -= 3) begin
      wr(OFS_DUTY, dt);
      settle();
      lo = 0;
      up = 0;
      for (k = 0; k < 100; k++) begin
        @(negedge mclk);
        lo += lower_drive_c;
        up += !upper_drive_a;
      end
      @(posedge mclk);
      chk("lower on cycles", dt * 10, lo);
      chk("upper on cycles", 100, up);
    end
    $display("test pwm done");
  endtask
  initial begin
    repeat (20) @(posedge mclk);
    rst_b <= 1;
    @(posedge mclk);
    t_regs();
    t_commutate();
    t_invalid();
    t_protect();
    t_pwm();
    finish_test();
  end
endmodule
`default_nettype wire

// >>> hcd_decoder.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_decoder (
  // Sensor code and configuration
  input  wire logic [2:0] code,
  input  wire logic       phase60,
  input  wire logic       fwd,
  // Selected phases, one-hot
  output logic      [2:0] top_sel,
  output logic      [2:0] bot_sel,
  output logic            valid
);
  import hcd_pkg::*;

  // Step index 0..5 of a code, POS_NONE when the code is invalid
  function automatic logic [2:0] step_of(input logic [2:0] c, input logic p60);
    logic [2:0] s;
    s = POS_NONE;
    case (c)
      HALL_100: s = 3'h0;
      HALL_110: s = 3'h1;
      HALL_111: s = p60 ? 3'h2 : POS_NONE;
      HALL_010: s = p60 ? POS_NONE : 3'h2;
      HALL_011: s = 3'h3;
      HALL_001: s = 3'h4;
      HALL_000: s = p60 ? 3'h5 : POS_NONE;
      HALL_101: s = p60 ? POS_NONE : 3'h5;
      default:  s = POS_NONE;
    endcase
    return s;
  endfunction

  function automatic logic [2:0] top_of(input logic [2:0] s);
    logic [2:0] p;
    p = PH_NONE;
    case (s)
      3'h0, 3'h5: p = PH_A;
      3'h1, 3'h2: p = PH_B;
      3'h3, 3'h4: p = PH_C;
      default:    p = PH_NONE;
    endcase
    return p;
  endfunction

  function automatic logic [2:0] bot_of(input logic [2:0] s);
    logic [2:0] p;
    p = PH_NONE;
    case (s)
      3'h0, 3'h1: p = PH_C;
      3'h2, 3'h3: p = PH_A;
      3'h4, 3'h5: p = PH_B;
      default:    p = PH_NONE;
    endcase
    return p;
  endfunction

  wire logic [2:0] step;
  wire logic [2:0] fwd_top;
  wire logic [2:0] fwd_bot;

  assign step    = step_of(code, phase60);
  assign valid   = (step != POS_NONE);
  assign fwd_top = top_of(step);
  assign fwd_bot = bot_of(step);
  // Reverse swaps the upper and lower phase of each step
  assign top_sel = fwd ? fwd_top : fwd_bot;
  assign bot_sel = fwd ? fwd_bot : fwd_top;
endmodule
`default_nettype wire

// >>> hcd_motor_model.sv
`timescale 1ns/1ps
`default_nettype none
module hcd_motor_model (
  // Rotor position and sensor fault injection
  input  wire logic [2:0] pos,
  input  wire logic       mode60,
  input  wire logic       inject,
  input  wire logic [2:0] inj_code,
  // Power switch gates
  input  wire logic       upper_drive_a,
  input  wire logic       upper_drive_b,
  input  wire logic       upper_drive_c,
  input  wire logic       lower_drive_a,
  input  wire logic       lower_drive_b,
  input  wire logic       lower_drive_c,
  // Sensor pins and leg short seen
  output logic            hall_in_a,
  output logic            hall_in_b,
  output logic            hall_in_c,
  output logic            shoot
);
  // Codes per 60 degree step, step 0 in the low bits
  localparam logic [17:0] SEQ60  = {3'h0, 3'h1, 3'h3, 3'h7, 3'h6, 3'h4};
  localparam logic [17:0] SEQ120 = {3'h5, 3'h1, 3'h3, 3'h2, 3'h6, 3'h4};
  logic [2:0] code;
  assign code = inject ? inj_code : mode60 ? SEQ60[pos*3 +: 3] : SEQ120[pos*3 +: 3];
  assign {hall_in_a, hall_in_b, hall_in_c} = code;
  // Upper and lower of one leg both on would short the supply
  assign shoot = (!upper_drive_a && lower_drive_a) || (!upper_drive_b && lower_drive_b)
               || (!upper_drive_c && lower_drive_c);
endmodule
`default_nettype wire

// >>> hcd_pkg.sv
`default_nettype none
package hcd_pkg;
  // Register byte offsets
  localparam logic [3:0] OFS_CTRL   = 4'h0;
  localparam logic [3:0] OFS_PERIOD = 4'h4;
  localparam logic [3:0] OFS_DUTY   = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'hc;

  // Control register fields
  localparam int CTRL_ENABLE  = 0;
  localparam int CTRL_PHASE60 = 1;
  localparam int CTRL_FWD     = 2;
  localparam logic [2:0] CTRL_RESET = 3'h6;

  // Status register fields
  localparam int ST_HALL_LSB  = 0;
  localparam int ST_VALID     = 3;
  localparam int ST_OVERCUR   = 4;
  localparam int ST_THERMAL   = 5;
  localparam int ST_LATCH     = 6;
  localparam int ST_UPPER_LSB = 8;
  localparam int ST_LOWER_LSB = 12;

  // Oscillator defaults
  localparam logic [15:0] PERIOD_RESET = 16'h03e7;
  localparam logic [15:0] DUTY_RESET   = 16'h0000;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Phase one-hot codes, bit 0 is phase A
  localparam logic [2:0] PH_A    = 3'h1;
  localparam logic [2:0] PH_B    = 3'h2;
  localparam logic [2:0] PH_C    = 3'h4;
  localparam logic [2:0] PH_NONE = 3'h0;
  localparam logic [2:0] UPPER_OFF = 3'h7;

  // Sensor codes, {a, b, c}
  localparam logic [2:0] HALL_000 = 3'h0;
  localparam logic [2:0] HALL_001 = 3'h1;
  localparam logic [2:0] HALL_010 = 3'h2;
  localparam logic [2:0] HALL_011 = 3'h3;
  localparam logic [2:0] HALL_100 = 3'h4;
  localparam logic [2:0] HALL_101 = 3'h5;
  localparam logic [2:0] HALL_110 = 3'h6;
  localparam logic [2:0] HALL_111 = 3'h7;
  localparam logic [2:0] POS_NONE = 3'h7;
endpackage
`default_nettype wire

// >>> hcd_top.sv
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module hcd_top #(
  parameter int PWM_W = 16
) (
  // Clock and reset
  input  wire logic        mclk,
  input  wire logic        rst_b,
  // Sensor and protection pins
  input  wire logic        hall_in_a,
  input  wire logic        hall_in_b,
  input  wire logic        hall_in_c,
  input  wire logic        overcurrent,
  input  wire logic        thermal_shutdown,
  // Power switch drives
  output logic             upper_drive_a,
  output logic             upper_drive_b,
  output logic             upper_drive_c,
  output logic             lower_drive_a,
  output logic             lower_drive_b,
  output logic             lower_drive_c,
  // AXI4-Lite write address
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [3:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready
);
  import hcd_pkg::*;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic mapped(input logic [3:0] a);
    return (a == OFS_CTRL) || (a == OFS_PERIOD) || (a == OFS_DUTY) || (a == OFS_STATUS);
  endfunction

  // Pin synchronisers: three stages, a change counts when stages two and three agree
  logic [4:0] pin_s1;
  logic [4:0] pin_s2;
  logic [4:0] pin_s3;
  logic [4:0] pin_q;
  wire  logic [4:0] pins;
  wire  logic [4:0] pin_agree;
  wire  logic [4:0] next_pin_q;

  assign pins       = {thermal_shutdown, overcurrent, hall_in_a, hall_in_b, hall_in_c};
  assign pin_agree  = ~(pin_s2 ^ pin_s3);
  assign next_pin_q = (pin_agree & pin_s3) | (~pin_agree & pin_q);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      pin_s1 <= 5'h00;
      pin_s2 <= 5'h00;
      pin_s3 <= 5'h00;
      pin_q  <= 5'h00;
    end else begin
      pin_s1 <= pins;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pin_q  <= next_pin_q;
    end
  end

  wire logic [2:0] hall_q;
  wire logic       oc_q;
  wire logic       therm_q;
  assign hall_q  = pin_q[2:0];
  assign oc_q    = pin_q[3];
  assign therm_q = pin_q[4];

  // Registers
  logic [2:0]       ctrl;
  logic [PWM_W-1:0] period;
  logic [PWM_W-1:0] duty;

  wire logic enable;
  wire logic phase60;
  wire logic fwd;
  assign enable  = ctrl[CTRL_ENABLE];
  assign phase60 = ctrl[CTRL_PHASE60];
  assign fwd     = ctrl[CTRL_FWD];

  // Decoder
  wire logic [2:0] top_sel;
  wire logic [2:0] bot_sel;
  wire logic       code_valid;

  hcd_decoder u_dec (
    .code    (hall_q),
    .phase60 (phase60),
    .fwd     (fwd),
    .top_sel (top_sel),
    .bot_sel (bot_sel),
    .valid   (code_valid)
  );

  // Oscillator and conduction latch
  logic [PWM_W-1:0] osc_cnt;
  logic             latch;
  wire  logic       cycle_start;
  wire  logic       duty_end;
  wire  logic       next_latch;
  wire  logic [PWM_W-1:0] next_osc_cnt;

  // A period written below the running count must still end the cycle at once
  assign cycle_start  = (osc_cnt >= period);
  assign next_osc_cnt = cycle_start ? '0 : osc_cnt + 1'b1;
  assign duty_end     = (next_osc_cnt >= duty);
  // Overcurrent or duty end clears; only the cycle start sets
  assign next_latch   = oc_q ? 1'b0 : (cycle_start ? !duty_end : (latch && !duty_end));

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      osc_cnt <= '0;
      latch   <= 1'b0;
    end else begin
      osc_cnt <= next_osc_cnt;
      latch   <= next_latch;
    end
  end

  // Drive outputs
  wire logic       run;
  wire logic [2:0] next_upper;
  wire logic [2:0] next_lower;
  logic      [2:0] upper;
  logic      [2:0] lower;

  assign run        = enable && code_valid && !oc_q && !therm_q;
  assign next_upper = run ? ~top_sel : UPPER_OFF;
  assign next_lower = (run && latch) ? bot_sel : PH_NONE;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      upper <= UPPER_OFF;
      lower <= PH_NONE;
    end else begin
      upper <= next_upper;
      lower <= next_lower;
    end
  end

  assign upper_drive_a = upper[0];
  assign upper_drive_b = upper[1];
  assign upper_drive_c = upper[2];
  assign lower_drive_a = lower[0];
  assign lower_drive_b = lower[1];
  assign lower_drive_c = lower[2];

  // Bus slave: address and data held until both are present
  logic        aw_held;
  logic        w_held;
  logic [3:0]  aw_addr;
  logic [31:0] w_data;
  logic [3:0]  w_strb;
  wire  logic  do_write;
  wire  logic  ar_take;
  wire  logic [31:0] status_word;
  wire  logic [31:0] read_mux;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held && !s_axi_bvalid;
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  assign status_word = {16'h0000, 1'b0, lower, 1'b0, upper, 1'b0, latch, therm_q, oc_q,
                        code_valid, hall_q};
  assign read_mux = (s_axi_araddr == OFS_CTRL)   ? {29'h0, ctrl} :
                    (s_axi_araddr == OFS_PERIOD) ? 32'(period) :
                    (s_axi_araddr == OFS_DUTY)   ? 32'(duty) :
                    (s_axi_araddr == OFS_STATUS) ? status_word : 32'h0000_0000;

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      aw_held <= 1'b0;
      aw_addr <= 4'h0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  wire logic [31:0] ctrl_merged;
  wire logic [31:0] period_merged;
  wire logic [31:0] duty_merged;
  assign ctrl_merged   = merge({29'h0, ctrl}, w_data, w_strb);
  assign period_merged = merge(32'(period), w_data, w_strb);
  assign duty_merged   = merge(32'(duty), w_data, w_strb);

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl   <= CTRL_RESET;
      period <= PWM_W'(PERIOD_RESET);
      duty   <= PWM_W'(DUTY_RESET);
    end else if (do_write) begin
      if (aw_addr == OFS_CTRL) begin
        ctrl <= ctrl_merged[2:0];
      end
      if (aw_addr == OFS_PERIOD) begin
        period <= period_merged[PWM_W-1:0];
      end
      if (aw_addr == OFS_DUTY) begin
        duty <= duty_merged[PWM_W-1:0];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= mapped(aw_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= read_mux;
      s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);

  property p_one_pair;
    (lower != PH_NONE) |-> ($onehot(~upper) && $onehot(lower) && ((~upper & lower) == PH_NONE));
  endproperty
  a_one_pair: assert property (p_one_pair) else $error("upper and lower drives not one each");

  property p_seq120;
    (run && !phase60 && fwd && hall_q == HALL_010) |=> (upper == ~PH_B);
  endproperty
  a_seq120: assert property (p_seq120) else $error("120 degree step 010 wrong upper");

  property p_fwd60;
    (run && phase60 && fwd && hall_q == HALL_111 && latch) |=> (upper == ~PH_B && lower == PH_A);
  endproperty
  a_fwd60: assert property (p_fwd60) else $error("60 degree step 111 wrong drive");

  property p_rev60;
    (run && phase60 && !fwd && hall_q == HALL_100) |=> (upper == ~PH_C);
  endproperty
  a_rev60: assert property (p_rev60) else $error("reverse 100 did not swap phases");

  property p_rev120;
    (run && !phase60 && !fwd && hall_q == HALL_101) |=> (upper == ~PH_B);
  endproperty
  a_rev120: assert property (p_rev120) else $error("reverse 120 step 101 wrong upper");

  property p_thermal;
    therm_q |=> (upper == UPPER_OFF && lower == PH_NONE);
  endproperty
  a_thermal: assert property (p_thermal) else $error("drive active in thermal shutdown");

  property p_invalid;
    (!phase60 && (hall_q == HALL_000 || hall_q == HALL_111)) |=> (upper == UPPER_OFF);
  endproperty
  a_invalid: assert property (p_invalid) else $error("invalid code left upper drive on");

  property p_disable;
    (!enable || oc_q) |=> (upper == UPPER_OFF && lower == PH_NONE);
  endproperty
  a_disable: assert property (p_disable) else $error("drive on while disabled or overcurrent");

  property p_oc_latch;
    oc_q |=> !latch;
  endproperty
  a_oc_latch: assert property (p_oc_latch) else $error("overcurrent did not clear latch");

  property p_one_pulse;
    (!latch && !cycle_start) |=> !latch;
  endproperty
  a_one_pulse: assert property (p_one_pulse) else $error("second pulse in one cycle");

  property p_gate;
    $past(run) |-> (lower == ($past(latch) ? $past(bot_sel) : PH_NONE));
  endproperty
  a_gate: assert property (p_gate) else $error("lower drive not gated by latch");

  c_drive: cover property (lower != PH_NONE);
  c_oc_cut: cover property (latch ##1 oc_q ##1 !latch);
  c_step: cover property (run && hall_q == HALL_100 ##[1:100] run && hall_q == HALL_110);
  c_write: cover property (do_write && aw_addr == OFS_CTRL);
endmodule
`default_nettype wire
